/* ftlr_params.svh */
`ifndef FTLR_PARAMS_SVH
`define FTLR_PARAMS_SVH
// clock and timing
`define FTLR_CLK_KHZ       50000
`define FTLR_CLK_NS        20
`define FTLR_LED_HALF_MS   500
`define FTLR_TACH_TICK_NS  1000
// register indices, byte address is four times the index
`define FTLR_IDX_DIVSEL    8'h58
`define FTLR_IDX_FIRST_COOLING_CHANNEL_CNT  8'h59
`define FTLR_IDX_SECOND_COOLING_CHANNEL_CNT  8'h5a
`define FTLR_IDX_FIRST_COOLING_CHANNEL_PRE  8'h5b
`define FTLR_IDX_SECOND_COOLING_CHANNEL_PRE  8'h5c
`define FTLR_IDX_IND1      8'h5d
`define FTLR_IDX_IND2      8'h5e
`define FTLR_IDX_KEY       8'h5f
`define FTLR_IDX_RSV_LO    8'h60
`define FTLR_IDX_RSV_HI    8'h7f
// field positions
`define FTLR_DIV1_LSB      4
`define FTLR_DIV2_LSB      6
// reset values
`define FTLR_RST_DIVSEL    8'h50
`define FTLR_RST_BYTE      8'h00
// bus responses
`define FTLR_RESP_OKAY     2'b00
`define FTLR_RESP_SLVERR   2'b10
`endif

/* ftlr_pkg.sv */
package ftlr_pkg;
  typedef logic [7:0] ftlr_byte_t;
  typedef enum logic [1:0] {
    FTLR_LED_OFF  = 2'b00,
    FTLR_LED_FAST = 2'b01,
    FTLR_LED_SLOW = 2'b10,
    FTLR_LED_ON   = 2'b11
  } ftlr_led_mode_t;
endpackage

/* ftlr_regs.sv */
// Operation
// R1: count clock ticks per fan pulse, eight bits
// R2: read value is last pulse's latched count
// R3: software ignores reading two pulses after preload
// R4: count starts from software preload value
// R5: preload write restarts that channel's count
// R6: indicator code 00 off, 11 on
// R7: code 01 blinks half second on/off
// R8: code 10 half second on, 1.5 off
// R9: reserved offsets 0x60-0x7f read zero
// R10: read/write eight-bit key code holding register
// R11: selectable count divisor, code 00 is one
// R12: synchronise tach inputs and detect edges
`timescale 1ns/1ps
`include "ftlr_params.svh"

module ftlr_regs #(
  parameter int unsigned ADDR_W       = 10,
  parameter int unsigned HALF_SEC_CYC = `FTLR_LED_HALF_MS * `FTLR_CLK_KHZ,
  parameter int unsigned TACH_DIV     = `FTLR_TACH_TICK_NS / `FTLR_CLK_NS
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // fan tachometer sense
  input  wire logic              first_cooling_channel_tach,
  input  wire logic              second_cooling_channel_tach,
  // indicators
  output logic                   first_indicator,
  output logic                   second_indicator
);

  localparam int unsigned HW = $clog2(HALF_SEC_CYC);
  localparam int unsigned TW = $clog2(TACH_DIV + 1);
  localparam logic [HW-1:0] HALF_LAST = HW'(HALF_SEC_CYC - 1);
  localparam logic [TW-1:0] TACH_LAST = TW'(TACH_DIV - 1);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // write channel capture
  logic              aw_held_r;
  logic              w_held_r;
  logic [7:0]        wr_idx_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  // read channel
  logic              rvalid_r;
  logic [7:0]        rdata_r;
  logic [1:0]        rresp_r;
  // software registers
  logic [3:0]        divsel_r;
  ftlr_pkg::ftlr_byte_t preload_r [2];
  ftlr_pkg::ftlr_led_mode_t mode_r [2];
  ftlr_pkg::ftlr_byte_t keycode_r;
  // timing
  logic [HW-1:0]     half_cnt_r;
  logic [1:0]        phase_r;
  logic [TW-1:0]     base_cnt_r;
  logic              led_r [2];
  // per-channel results
  logic [7:0]        cnt_w [2];
  logic [7:0]        tach_w [2];
  logic              edge_w [2];
  logic              tick_w [2];
  logic              pre_wr [2];
  logic              tach_in [2];

  assign tach_in[0] = first_cooling_channel_tach;
  assign tach_in[1] = second_cooling_channel_tach;

  // bus handshakes
  wire wr_go    = aw_held_r && w_held_r && !bvalid_r;
  wire wr_en    = wr_go && wstrb0_r;
  wire rd_go    = arvalid && !rvalid_r;
  wire [7:0] rd_idx = araddr[ADDR_W-1:2];
  wire wr_known = wr_idx_r >= `FTLR_IDX_DIVSEL && wr_idx_r <= `FTLR_IDX_RSV_HI;
  wire rd_known = rd_idx >= `FTLR_IDX_DIVSEL && rd_idx <= `FTLR_IDX_RSV_HI;

  assign awready = !aw_held_r && !bvalid_r;
  assign wready  = !w_held_r && !bvalid_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = {24'h000000, rdata_r};

  // write decode
  assign pre_wr[0] = wr_en && wr_idx_r == `FTLR_IDX_FIRST_COOLING_CHANNEL_PRE;
  assign pre_wr[1] = wr_en && wr_idx_r == `FTLR_IDX_SECOND_COOLING_CHANNEL_PRE;
  wire wr_div  = wr_en && wr_idx_r == `FTLR_IDX_DIVSEL;
  wire wr_ind1 = wr_en && wr_idx_r == `FTLR_IDX_IND1;
  wire wr_ind2 = wr_en && wr_idx_r == `FTLR_IDX_IND2;
  wire wr_key  = wr_en && wr_idx_r == `FTLR_IDX_KEY;

  // read selection, reserved window falls through to zero
  // R9 reserved reads zero
  wire [7:0] rd_val =
    rd_idx == `FTLR_IDX_DIVSEL   ? {divsel_r, 4'h0} :
    rd_idx == `FTLR_IDX_FIRST_COOLING_CHANNEL_CNT ? tach_w[0] :
    rd_idx == `FTLR_IDX_SECOND_COOLING_CHANNEL_CNT ? tach_w[1] :
    rd_idx == `FTLR_IDX_FIRST_COOLING_CHANNEL_PRE ? preload_r[0] :
    rd_idx == `FTLR_IDX_SECOND_COOLING_CHANNEL_PRE ? preload_r[1] :
    rd_idx == `FTLR_IDX_IND1     ? {6'h00, mode_r[0]} :
    rd_idx == `FTLR_IDX_IND2     ? {6'h00, mode_r[1]} :
    rd_idx == `FTLR_IDX_KEY      ? keycode_r : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      wr_idx_r  <= awaddr[ADDR_W-1:2];
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r  <= wdata[7:0];
      wstrb0_r <= wstrb[0];
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // writes to read-only or reserved words are dropped but answered okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `FTLR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_known ? `FTLR_RESP_OKAY : `FTLR_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= `FTLR_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_known ? `FTLR_RESP_OKAY : `FTLR_RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divsel_r     <= 4'(`FTLR_RST_DIVSEL >> `FTLR_DIV1_LSB);
      preload_r[0] <= `FTLR_RST_BYTE;
      preload_r[1] <= `FTLR_RST_BYTE;
      mode_r[0]    <= ftlr_pkg::FTLR_LED_OFF;
      mode_r[1]    <= ftlr_pkg::FTLR_LED_OFF;
      keycode_r    <= `FTLR_RST_BYTE;
    end else begin
      if (wr_div)
        divsel_r <= wdata_r[7:4];
      if (pre_wr[0])
        preload_r[0] <= wdata_r;
      if (pre_wr[1])
        preload_r[1] <= wdata_r;
      if (wr_ind1)
        mode_r[0] <= ftlr_pkg::ftlr_led_mode_t'(wdata_r[1:0]);
      if (wr_ind2)
        mode_r[1] <= ftlr_pkg::ftlr_led_mode_t'(wdata_r[1:0]);
      // R10 key code store
      if (wr_key)
        keycode_r <= wdata_r;
    end
  end

  // shared count-clock prescaler
  wire base_tick = base_cnt_r == TACH_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn || base_tick)
      base_cnt_r <= '0;
    else
      base_cnt_r <= base_cnt_r + 1'b1;
  end

  genvar g;
  for (g = 0; g < 2; g++) begin : g_tach
    logic       s1_r;
    logic       s2_r;
    logic       s3_r;
    logic [2:0] div_cnt_r;
    logic [7:0] cnt_r;
    logic [7:0] tach_r;
    wire  [1:0] dsel = divsel_r[2*g+1 -: 2];
    wire  [2:0] mask = 3'((4'b0001 << dsel) - 4'b0001);

    // R12 sync then edge
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= tach_in[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    assign edge_w[g] = s2_r && !s3_r;

    // R11 divided count clock
    assign tick_w[g] = base_tick && ((div_cnt_r & mask) == mask);
    always_ff @(posedge aclk) begin
      if (!aresetn || pre_wr[g])
        div_cnt_r <= 3'h0;
      else if (base_tick)
        div_cnt_r <= div_cnt_r + 1'b1;
    end

    // R1 R4 R5 preload and count
    always_ff @(posedge aclk) begin
      if (!aresetn)
        cnt_r <= `FTLR_RST_BYTE;
      else if (pre_wr[g])
        cnt_r <= wdata_r;
      else if (edge_w[g])
        cnt_r <= preload_r[g];
      else if (tick_w[g] && cnt_r != 8'hff)
        cnt_r <= cnt_r + 1'b1;
    end

    // R2 latch final count; R3 reading settles after two pulses
    always_ff @(posedge aclk) begin
      if (!aresetn)
        tach_r <= `FTLR_RST_BYTE;
      else if (edge_w[g])
        tach_r <= cnt_r;
    end
    assign cnt_w[g]  = cnt_r;
    assign tach_w[g] = tach_r;
  end

  // half-second time base, phase counts a two-second frame
  wire half_tick = half_cnt_r == HALF_LAST;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_r <= '0;
      phase_r    <= 2'b00;
    end else if (half_tick) begin
      half_cnt_r <= '0;
      phase_r    <= phase_r + 1'b1;
    end else begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  for (g = 0; g < 2; g++) begin : g_led
    // R6 R7 R8 pattern select
    wire on_now = mode_r[g] == ftlr_pkg::FTLR_LED_ON ||
                  (mode_r[g] == ftlr_pkg::FTLR_LED_FAST && !phase_r[0]) ||
                  (mode_r[g] == ftlr_pkg::FTLR_LED_SLOW && phase_r == 2'b00);
    always_ff @(posedge aclk) begin
      if (!aresetn)
        led_r[g] <= 1'b0;
      else
        led_r[g] <= on_now;
    end
  end
  assign first_indicator  = led_r[0];
  assign second_indicator = led_r[1];

  sequence s_pre_wr0;
    wr_en && wr_idx_r == `FTLR_IDX_FIRST_COOLING_CHANNEL_PRE;
  endsequence

  sequence s_pulse_end0;
    edge_w[0] && !pre_wr[0];
  endsequence

  a_preload_restart: assert property (s_pre_wr0 |=> cnt_w[0] == $past(wdata_r)) // R5
    else $error("preload write did not restart count");

  a_count_reload: assert property (s_pulse_end0 |=> cnt_w[0] == $past(preload_r[0])) // R4
    else $error("count did not start from preload");

  a_tach_latch: assert property (s_pulse_end0 |=> tach_w[0] == $past(cnt_w[0]) ##1 tach_w[0] == $past(tach_w[0])) // R2
    else $error("tach value not latched at pulse end");

  a_count_hold_max: assert property (cnt_w[1] == 8'hff && !edge_w[1] && !pre_wr[1] |=> cnt_w[1] == 8'hff) // R1
    else $error("count wrapped past maximum");

  a_edge_sync: assert property (edge_w[0] |-> $past(tach_in[0], 2) && !$past(tach_in[0], 3)) // R12
    else $error("edge without synchronised rise");

  a_div_one: assert property (divsel_r[1:0] == 2'b00 |-> tick_w[0] == base_tick) // R11
    else $error("divisor one not passing every tick");

  a_led_off: assert property (mode_r[0] == ftlr_pkg::FTLR_LED_OFF |=> !first_indicator) // R6
    else $error("indicator lit while off");

  a_led_on: assert property (mode_r[1] == ftlr_pkg::FTLR_LED_ON |=> second_indicator) // R6
    else $error("indicator dark while on");

  a_led_fast: assert property (mode_r[0] == ftlr_pkg::FTLR_LED_FAST |=> first_indicator == !$past(phase_r[0])) // R7
    else $error("fast blink phase wrong");

  a_led_slow: assert property (mode_r[1] == ftlr_pkg::FTLR_LED_SLOW |=> second_indicator == ($past(phase_r) == 2'b00)) // R8
    else $error("slow blink phase wrong");

  a_rsvd_zero: assert property (rd_go && rd_idx >= `FTLR_IDX_RSV_LO && rd_idx <= `FTLR_IDX_RSV_HI |=> rvalid && rdata == 32'h00000000) // R9
    else $error("reserved read not zero");

  a_key_store: assert property (wr_key |=> keycode_r == $past(wdata_r) ##[0:2] keycode_r == $past(keycode_r)) // R10
    else $error("key code not stored");

endmodule // ftlr_regs

/* ftlr_fan_model.sv */
`timescale 1ns/1ps
module ftlr_fan_model (
  // link
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic [31:0] half,
  // sense line
  output logic             tach
);
  int cnt;
  // stopped fan stands low, first rise one half period after start
  always @(posedge aclk) begin
    if (!run) begin
      tach <= 1'b0;
      cnt  <= 0;
    end else if (cnt >= half - 1) begin
      tach <= ~tach;
      cnt  <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ftlr_fan_model

/* testbench.sv */
`timescale 1ns/1ps
`include "ftlr_params.svh"
module testbench;
  localparam int HALF = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, t1, t2, i1, i2, run1, run2;
  logic [1:0]  bresp, rresp, r;
  int          half1, half2, n_errors, checks, c1, c2, v;
  int          mdl [int];
  int          on_exp [4];

  ftlr_regs #(.HALF_SEC_CYC(HALF), .TACH_DIV(2)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .first_cooling_channel_tach(t1),
    .second_cooling_channel_tach(t2), .first_indicator(i1), .second_indicator(i2));
  ftlr_fan_model u_first_cooling_channel (.aclk(aclk), .run(run1), .half(half1), .tach(t1));
  ftlr_fan_model u_second_cooling_channel (.aclk(aclk), .run(run2), .half(half2), .tach(t2));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [1:0] resp_of(input int i);
    return (i >= `FTLR_IDX_DIVSEL && i <= `FTLR_IDX_RSV_HI) ? `FTLR_RESP_OKAY : `FTLR_RESP_SLVERR;
  endfunction
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input int i, input logic [31:0] dv);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= {i[7:0], 2'b00};
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    check(r, resp_of(i));
    // lane zero strobe gates the byte; reserved bits read back as zero
    if (wstrb[0] && mdl.exists(i) && i < `FTLR_IDX_RSV_LO &&
        i != `FTLR_IDX_FIRST_COOLING_CHANNEL_CNT && i != `FTLR_IDX_SECOND_COOLING_CHANNEL_CNT)
      mdl[i] = dv[7:0] & ((i == `FTLR_IDX_DIVSEL) ? 8'hf0 :
                          (i == `FTLR_IDX_IND1 || i == `FTLR_IDX_IND2) ? 8'h03 : 8'hff);
  endtask
  task automatic rd(input int i);
    logic ta, tr;
    @(posedge aclk);
    araddr <= {i[7:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    check(r, resp_of(i));
  endtask
  task automatic rd_cmp(input int i);
    rd(i);
    check(d, mdl.exists(i) ? mdl[i] : 0);
  endtask
  task automatic near(input int i, input int exp);
    rd(i);
    check({31'h0, int'(d) >= exp - 2 && int'(d) <= exp + 2}, 32'h1);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run1, run2} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    half1 = 20;
    half2 = 300;
    aresetn = 1'b0;
    on_exp = '{0, 4 * HALF, 2 * HALF, 8 * HALF};
    void'($urandom(32'hdb04));
    for (int i = `FTLR_IDX_DIVSEL; i <= `FTLR_IDX_RSV_HI; i++) mdl[i] = 0;
    mdl[`FTLR_IDX_DIVSEL] = `FTLR_RST_DIVSEL;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = `FTLR_IDX_DIVSEL; i <= `FTLR_IDX_RSV_LO; i++) rd_cmp(i);
    wr(`FTLR_IDX_RSV_LO, $urandom);
    rd_cmp(`FTLR_IDX_RSV_LO);
    rd_cmp(`FTLR_IDX_RSV_HI);
    rd_cmp(0);
    wr(0, 32'h0);
    repeat (4) begin
      wr(`FTLR_IDX_KEY, $urandom);
      rd_cmp(`FTLR_IDX_KEY);
    end
    // lane zero strobe low leaves the key code alone
    wstrb <= 4'he;
    wr(`FTLR_IDX_KEY, $urandom);
    wstrb <= 4'hf;
    rd_cmp(`FTLR_IDX_KEY);
    wr(`FTLR_IDX_DIVSEL, 32'h0);
    rd_cmp(`FTLR_IDX_DIVSEL);
    v = $urandom_range(8'h40);
    wr(`FTLR_IDX_FIRST_COOLING_CHANNEL_PRE, v);
    run1 <= 1'b1;
    wr(`FTLR_IDX_SECOND_COOLING_CHANNEL_PRE, 32'hf0);
    run2 <= 1'b1;
    rd_cmp(`FTLR_IDX_FIRST_COOLING_CHANNEL_PRE);
    repeat (half1 + 4) @(posedge aclk);
    // write to first latch spans half1 plus about four cycles
    near(`FTLR_IDX_FIRST_COOLING_CHANNEL_CNT, v + (half1 + 4) / 2);
    // software waits out two pulses after a preload
    repeat (4 * half1) @(posedge aclk);
    near(`FTLR_IDX_FIRST_COOLING_CHANNEL_CNT, v + half1);
    repeat (2 * half1) @(posedge aclk);
    near(`FTLR_IDX_FIRST_COOLING_CHANNEL_CNT, v + half1);
    repeat (4 * half2) @(posedge aclk);
    rd(`FTLR_IDX_SECOND_COOLING_CHANNEL_CNT);
    check(d, 32'hff);
    // slower fan one at /4, fan two restarted from zero at /2
    half1 <= 80;
    wr(`FTLR_IDX_DIVSEL, 32'h60);
    rd_cmp(`FTLR_IDX_DIVSEL);
    wr(`FTLR_IDX_SECOND_COOLING_CHANNEL_PRE, 32'h00);
    repeat (5 * half2) @(posedge aclk);
    near(`FTLR_IDX_FIRST_COOLING_CHANNEL_CNT, v + half1 / 4);
    near(`FTLR_IDX_SECOND_COOLING_CHANNEL_CNT, half2 / 2);
    for (int m = 0; m < 4; m++) begin
      wr(`FTLR_IDX_IND1, m);
      wr(`FTLR_IDX_IND2, 3 - m);
      rd_cmp(`FTLR_IDX_IND1);
      rd_cmp(`FTLR_IDX_IND2);
      repeat (4) @(posedge aclk);
      c1 = 0;
      c2 = 0;
      repeat (8 * HALF) begin
        @(negedge aclk);
        c1 += (i1 === 1'b1);
        c2 += (i2 === 1'b1);
      end
      check(c1, on_exp[m]);
      check(c2, on_exp[3 - m]);
    end
    give_verdict();
  end
endmodule // testbench
